// ==== hdl/ldc_top.sv ====
// Notes on behaviour
// - data falling while clock high is a start.
// - data rising while clock high is a stop.
// - data changes only while clock low, except start and stop.
// - repeated start restarts address reception like a first start.
// - bytes are eight bits, most significant first.
// - target holds data low through ninth clock to acknowledge the address, register and value bytes of a write.
// - first byte: seven address bits then direction, 0 write 1 read.
// - target answers only address 36 hex.
// - write: second byte selects register, third is its value.
// - enable register holds main, sub and keypad enable bits.
// - pump unity gain; any active bank sink near 375mV selects 3/2.
// - only enabled main or sub bank sinks join the gain decision.
// - keypad enabled with both display banks off forces 3/2.
// - an unconnected enabled bank sink forces 3/2.
// - sixteen duty levels per display bank, four keypad levels.
// - brightness register: main code low nibble, sub code high nibble.
// - keypad code is two low bits, 11 full scale, rest unused.
// - keypad codes give 100, 70, 40, 20 percent of full scale.
`timescale 1ns/1ps
`default_nettype none
module ldc_top
    import ldc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // analog sink sense from the current sinks
    input wire logic [3:0] main_low,
    input wire logic [1:0] sub_low,
    input wire logic [3:0] main_open,
    input wire logic [1:0] sub_open,
    // controls to the analog side
    output ldc_ctrl_t ctrl,
    output logic gain_three_halves,
    output logic bus_busy
);

    ////////////////////////////////////////////////////////////////////////////

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RECV = 5'b00010,
        ST_ACK = 5'b00100,
        ST_IGNORE = 5'b01000,
        ST_DONE = 5'b10000
    } ldc_phase_t;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_d;
        logic sda_d;
        ldc_phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [1:0] byte_idx;
        logic [7:0] reg_addr;
        logic ack_drive;
        logic busy;
        logic [7:0] enable_r;
        logic [7:0] bright_r;
        logic [7:0] keypad_r;
    } ldc_state_t;

    ldc_state_t st_r;
    ldc_state_t st_nxt;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    ldc_sense_t sense;

    // keypad analog scale in percent of full scale
    function automatic logic [6:0] key_percent(input logic [1:0] code);
        logic [6:0] p;
        p = 7'h14;
        unique case (code)
            2'b11: p = 7'h64;
            2'b10: p = 7'h46;
            2'b01: p = 7'h28;
            2'b00: p = 7'h14;
        endcase
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    // only the second stage of each synchroniser is observed
    assign scl_s = st_r.scl_sync[1];
    assign sda_s = st_r.sda_sync[1];
    assign scl_rise = scl_s & ~st_r.scl_d;
    assign scl_fall = ~scl_s & st_r.scl_d;
    assign start_seen = scl_s & st_r.scl_d & st_r.sda_d & ~sda_s;
    assign stop_seen = scl_s & st_r.scl_d & ~st_r.sda_d & sda_s;

    always_comb begin
        st_nxt = st_r;
        st_nxt.scl_sync = {st_r.scl_sync[0], scl_in};
        st_nxt.sda_sync = {st_r.sda_sync[0], sda_in};
        st_nxt.scl_d = scl_s;
        st_nxt.sda_d = sda_s;

        if (start_seen) begin
            // repeated start behaves as a first start
            st_nxt.phase = ST_RECV;
            st_nxt.bit_cnt = 4'h0;
            st_nxt.byte_idx = 2'h0;
            st_nxt.ack_drive = 1'b0;
            st_nxt.busy = 1'b1;
        end else if (stop_seen) begin
            st_nxt.phase = ST_IDLE;
            st_nxt.ack_drive = 1'b0;
            st_nxt.busy = 1'b0;
        end else begin
            unique case (st_r.phase)
                ST_IDLE: begin
                    st_nxt.ack_drive = 1'b0;
                end
                ST_RECV: begin
                    // data sampled on rising clock, stable while high
                    if (scl_rise) begin
                        st_nxt.shift = {st_r.shift[6:0], sda_s};
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                    end
                    if (scl_fall && st_r.bit_cnt == LDC_BYTE_BITS) begin
                        st_nxt.bit_cnt = 4'h0;
                        if (st_r.byte_idx == 2'h0) begin
                            // read requests are not supported, so left unacked
                            if (st_r.shift[7:1] == LDC_DEV_ADDR && !st_r.shift[0]) begin
                                st_nxt.phase = ST_ACK;
                                st_nxt.ack_drive = 1'b1;
                            end else begin
                                st_nxt.phase = ST_IGNORE;
                            end
                        end else begin
                            st_nxt.phase = ST_ACK;
                            st_nxt.ack_drive = 1'b1;
                            if (st_r.byte_idx == 2'h1) begin
                                st_nxt.reg_addr = st_r.shift;
                            end else begin
                                // unmapped addresses are acked but discarded
                                unique case (st_r.reg_addr)
                                    LDC_OFS_ENABLE:
                                        st_nxt.enable_r = st_r.shift & LDC_MASK_ENABLE;
                                    LDC_OFS_DISP_BRIGHT:
                                        st_nxt.bright_r = st_r.shift;
                                    LDC_OFS_KEY_BRIGHT:
                                        st_nxt.keypad_r = st_r.shift & LDC_MASK_KEY;
                                    default: ;
                                endcase
                            end
                        end
                    end
                end
                ST_ACK: begin
                    // hold low over the whole ninth pulse, release on its fall
                    if (scl_fall) begin
                        st_nxt.ack_drive = 1'b0;
                        st_nxt.phase = (st_r.byte_idx == 2'h2) ? ST_DONE : ST_RECV;
                        st_nxt.byte_idx = (st_r.byte_idx == 2'h2) ? 2'h2
                            : st_r.byte_idx + 2'h1;
                    end
                end
                ST_IGNORE: begin
                    st_nxt.ack_drive = 1'b0;
                end
                ST_DONE: begin
                    // further bytes are left unacknowledged until a new start
                    st_nxt.ack_drive = 1'b0;
                end
                default: begin
                    st_nxt.phase = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.scl_sync <= 2'b11;
            st_r.sda_sync <= 2'b11;
            st_r.scl_d <= 1'b1;
            st_r.sda_d <= 1'b1;
            st_r.phase <= ST_IDLE;
            st_r.enable_r <= LDC_RST_ENABLE;
            st_r.bright_r <= LDC_RST_DISP_BRIGHT;
            st_r.keypad_r <= LDC_RST_KEY_BRIGHT;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = st_r.ack_drive;
    assign bus_busy = st_r.busy;

    always_comb begin
        ctrl.main_bank_enable = st_r.enable_r[LDC_POS_MAIN_EN];
        ctrl.sub_bank_enable = st_r.enable_r[LDC_POS_SUB_EN];
        ctrl.keypad_enable = st_r.enable_r[LDC_POS_KEY_EN];
        ctrl.main_level_code = st_r.bright_r[LDC_POS_MAIN_LVL +: 4];
        ctrl.sub_level_code = st_r.bright_r[LDC_POS_SUB_LVL +: 4];
        ctrl.keypad_level_code = st_r.keypad_r[LDC_POS_KEY_LVL +: 2];
        ctrl.keypad_percent = key_percent(st_r.keypad_r[LDC_POS_KEY_LVL +: 2]);
    end

    assign sense.main_low = main_low;
    assign sense.sub_low = sub_low;
    assign sense.main_open = main_open;
    assign sense.sub_open = sub_open;

    ldc_gain_sel u_gain (
        .clock(clock),
        .rst_n(rst_n),
        .ctrl(ctrl),
        .sense(sense),
        .gain_three_halves(gain_three_halves)
    );

endmodule // ldc_top
`default_nettype wire

// ==== hdl/ldc_pkg.sv ====
`default_nettype none
package ldc_pkg;

    localparam logic [6:0] LDC_DEV_ADDR = 7'h36;
    localparam logic [7:0] LDC_OFS_ENABLE = 8'h10;
    localparam logic [7:0] LDC_OFS_DISP_BRIGHT = 8'ha0;
    localparam logic [7:0] LDC_OFS_KEY_BRIGHT = 8'hb0;
    localparam logic [7:0] LDC_RST_ENABLE = 8'h00;
    localparam logic [7:0] LDC_RST_DISP_BRIGHT = 8'h00;
    localparam logic [7:0] LDC_RST_KEY_BRIGHT = 8'h00;
    localparam int LDC_POS_MAIN_EN = 0;
    localparam int LDC_POS_SUB_EN = 1;
    localparam int LDC_POS_KEY_EN = 2;
    localparam int LDC_POS_MAIN_LVL = 0;
    localparam int LDC_POS_SUB_LVL = 4;
    localparam int LDC_POS_KEY_LVL = 0;
    localparam logic [7:0] LDC_MASK_ENABLE = 8'h07;
    localparam logic [7:0] LDC_MASK_KEY = 8'h03;
    localparam logic [3:0] LDC_BYTE_BITS = 4'h8;

    typedef struct packed {
        logic main_bank_enable;
        logic sub_bank_enable;
        logic keypad_enable;
        logic [3:0] main_level_code;
        logic [3:0] sub_level_code;
        logic [1:0] keypad_level_code;
        logic [6:0] keypad_percent;
    } ldc_ctrl_t;

    typedef struct packed {
        logic [3:0] main_low;
        logic [1:0] sub_low;
        logic [3:0] main_open;
        logic [1:0] sub_open;
    } ldc_sense_t;

endpackage
`default_nettype wire

// ==== hdl/ldc_gain_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
module ldc_gain_sel
    import ldc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control and analog sense
    input wire ldc_ctrl_t ctrl,
    input wire ldc_sense_t sense,
    // gain request
    output logic gain_three_halves
);

    typedef struct packed {
        ldc_sense_t s1;
        ldc_sense_t s2;
        logic gain;
    } ldc_gain_state_t;

    ldc_gain_state_t st_r;
    ldc_gain_state_t st_nxt;
    logic main_hit;
    logic sub_hit;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = sense;
        st_nxt.s2 = st_r.s1;
        // only enabled display banks are watched; keypad never is
        main_hit = ctrl.main_bank_enable &
            (|st_r.s2.main_low | |st_r.s2.main_open);
        sub_hit = ctrl.sub_bank_enable &
            (|st_r.s2.sub_low | |st_r.s2.sub_open);
        // keypad alone would lack headroom at unity gain
        st_nxt.gain = main_hit | sub_hit |
            (ctrl.keypad_enable & ~ctrl.main_bank_enable & ~ctrl.sub_bank_enable);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign gain_three_halves = st_r.gain;

endmodule // ldc_gain_sel
`default_nettype wire

// ==== verification/ldc_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module ldc_top_chk
    import ldc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // sense and control
    input wire logic [3:0] main_low,
    input wire logic [1:0] sub_low,
    input wire logic [3:0] main_open,
    input wire logic [1:0] sub_open,
    input wire ldc_ctrl_t ctrl,
    input wire logic gain_three_halves,
    input wire logic bus_busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic m_en = ctrl.main_bank_enable;
    wire logic s_en = ctrl.sub_bank_enable;
    wire logic k_en = ctrl.keypad_enable;
    wire logic [1:0] kc = ctrl.keypad_level_code;
    ////////////////////////////////////////
    // raw pins: the two-flop sync delay fits inside the five-clock window
    a_start_busy: assert property ($fell(sda_in) && scl_in |-> ##[1:5] bus_busy)
        else $error("start did not mark bus busy");
    a_stop_free: assert property ($rose(sda_in) && scl_in |-> ##[1:5] !bus_busy)
        else $error("stop did not free bus");
    a_ack_edge: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("ack drive changed while clock high");
    a_key_pct: assert property ($stable(kc) && kc != 2'h0
        |-> ctrl.keypad_percent == (kc == 2'h3 ? 7'h64 : kc == 2'h2 ? 7'h46 : 7'h28))
        else $error("keypad percent wrong");
    // sense needs sync plus one register, enables one register only, so four or five stable cycles suffice
    a_key_only: assert property ((k_en && !m_en && !s_en)[*4] |-> gain_three_halves)
        else $error("keypad alone not at 3/2");
    a_all_off: assert property ((!m_en && !s_en && !k_en)[*4] |-> !gain_three_halves)
        else $error("gain raised with nothing enabled");
    a_main_low: assert property ((m_en && |main_low)[*5] |-> gain_three_halves)
        else $error("low main sink ignored");
    a_sub_open: assert property ((s_en && |sub_open)[*5] |-> gain_three_halves)
        else $error("open sub sink ignored");
    a_main_open: assert property ((m_en && |main_open)[*5] |-> gain_three_halves)
        else $error("open main sink ignored");
    a_sub_low: assert property ((s_en && |sub_low)[*5] |-> gain_three_halves)
        else $error("low sub sink ignored");
    a_main_idle: assert property ((!m_en && s_en && !k_en && sub_low == 2'h0
        && sub_open == 2'h0)[*5] |-> !gain_three_halves)
        else $error("disabled bank changed gain");
    c_ack: cover property ($rose(sda_oe));
    c_gain: cover property ($rose(gain_three_halves));
    c_stop: cover property ($fell(bus_busy));
endmodule // ldc_top_chk
bind ldc_top ldc_top_chk i_chk (.clock, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe,
    .main_low, .sub_low, .main_open, .sub_open, .ctrl, .gain_three_halves, .bus_busy);
`default_nettype wire

// ==== verification/ldc_bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module ldc_bus_master (
    // clock
    input wire logic clock,
    // bus lines
    input wire logic sda_wire,
    output logic scl,
    output logic sda_low
);
    int half = 5;
    // bus clock idles high and only toggles inside frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////
    task automatic tick();
        repeat (half) @(negedge clock);
    endtask
    task automatic start_cond();
        sda_low = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b1;
        tick();
        scl = 1'b0;
        @(negedge clock);
    endtask
    // data moves one clock after the bus clock falls, never together with it
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low = !b[i];
            tick();
            scl = 1'b1;
            tick();
            scl = 1'b0;
            @(negedge clock);
        end
        sda_low = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        ack = !sda_wire;
        scl = 1'b0;
        @(negedge clock);
    endtask
    task automatic stop_cond();
        sda_low = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b0;
        tick();
    endtask
endmodule // ldc_bus_master
`default_nettype wire

// ==== verification/ldc_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ldc_top_tb_top
    import ldc_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] main_low = 4'h0;
    logic [3:0] main_open = 4'h0;
    logic [1:0] sub_low = 2'h0;
    logic [1:0] sub_open = 2'h0;
    wire logic scl, mst_low, sda_out, sda_oe, gain, busy, sda_w;
    wire ldc_ctrl_t ctrl;
    logic [7:0] gp = 8'h00, br = 8'h00, kp = 8'h00;
    logic [6:0] pct [4] = '{7'h14, 7'h28, 7'h46, 7'h64};
    int n_errors = 0;
    int n_tests = 0;
    always #5 clock = ~clock;
    // pulled-up wire: low when either party pulls
    assign sda_w = !(mst_low || (sda_oe && !sda_out));
    ldc_top i_dut (.clock, .rst_n, .scl_in(scl), .sda_in(sda_w), .sda_out, .sda_oe, .main_low,
        .sub_low, .main_open, .sub_open, .ctrl, .gain_three_halves(gain),
        .bus_busy(busy));
    ldc_bus_master i_mst (.clock, .sda_wire(sda_w), .scl, .sda_low(mst_low));
    ////////////////////////////////////////
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic ldc_ctrl_t ex();
        return '{gp[0], gp[1], gp[2], br[3:0], br[7:4], kp[1:0], pct[kp[1:0]]};
    endfunction
    task automatic wr(input logic [7:0] a, r, d, input logic [2:0] ea);
        logic [2:0] k;
        i_mst.start_cond();
        i_mst.send_byte(a, k[2]);
        i_mst.send_byte(r, k[1]);
        i_mst.send_byte(d, k[0]);
        i_mst.stop_cond();
        chk(20'(k), 20'(ea));
    endtask
    task automatic wreg(input logic [7:0] r, d);
        wr(8'h6c, r, d, 3'h7);
        if (r == LDC_OFS_ENABLE) gp = d & LDC_MASK_ENABLE;
        if (r == LDC_OFS_DISP_BRIGHT) br = d;
        if (r == LDC_OFS_KEY_BRIGHT) kp = d & LDC_MASK_KEY;
        chk(ctrl, ex());
    endtask
    task automatic gain_case(input logic [7:0] g, input logic [3:0] ml, mo,
        input logic [1:0] sl, so, input logic e);
        wreg(LDC_OFS_ENABLE, g);
        main_low = ml;
        main_open = mo;
        sub_low = sl;
        sub_open = so;
        repeat (6) @(negedge clock);
        chk(20'(gain), 20'(e));
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        chk(20'(ctrl[19:7]), 20'h0);
        chk(20'({busy, gain, sda_oe}), 20'h0);
        wreg(8'h10, 8'hff);
        wreg(8'ha0, 8'ha5);
        wreg(8'hb0, 8'hfe);
        wreg(8'h11, 8'h3c);
    endtask
    task automatic t_levels();
        i_mst.half = 12;
        for (int c = 3; c >= 0; c--) wreg(8'hb0, 8'(c));
        i_mst.half = 5;
    endtask
    task automatic t_refuse();
        logic [3:0] k;
        wr(8'h6e, 8'h10, 8'h00, 3'h0);
        wr(8'h6d, 8'ha0, 8'h00, 3'h0);
        chk(ctrl, ex());
        // a fourth byte goes unacknowledged and must not overwrite the data byte
        i_mst.start_cond();
        i_mst.send_byte(8'h6c, k[3]);
        i_mst.send_byte(8'h10, k[2]);
        i_mst.send_byte(8'h02, k[1]);
        i_mst.send_byte(8'h05, k[0]);
        i_mst.stop_cond();
        gp = 8'h02;
        chk(20'(k), 20'he);
        chk(ctrl, ex());
    endtask
    task automatic t_restart();
        logic [4:0] k;
        i_mst.start_cond();
        i_mst.send_byte(8'h6c, k[4]);
        i_mst.send_byte(8'h10, k[3]);
        i_mst.start_cond();
        i_mst.send_byte(8'h6c, k[2]);
        i_mst.send_byte(8'ha0, k[1]);
        i_mst.send_byte(8'h3c, k[0]);
        chk(20'(busy), 20'h1);
        i_mst.stop_cond();
        br = 8'h3c;
        chk(20'(k), 20'h1f);
        chk(ctrl, ex());
        chk(20'(busy), 20'h0);
    endtask
    task automatic t_gain();
        gain_case(8'h00, 4'hf, 4'hf, 2'h3, 2'h3, 1'b0);
        gain_case(8'h02, 4'hf, 4'hf, 2'h0, 2'h0, 1'b0);
        gain_case(8'h01, 4'h4, 4'h0, 2'h0, 2'h0, 1'b1);
        gain_case(8'h01, 4'h0, 4'h0, 2'h3, 2'h3, 1'b0);
        gain_case(8'h01, 4'h0, 4'h2, 2'h0, 2'h0, 1'b1);
        gain_case(8'h02, 4'h0, 4'h0, 2'h1, 2'h0, 1'b1);
        gain_case(8'h03, 4'h0, 4'h0, 2'h0, 2'h2, 1'b1);
        gain_case(8'h04, 4'h0, 4'h0, 2'h0, 2'h0, 1'b1);
        gain_case(8'h05, 4'h0, 4'h0, 2'h0, 2'h0, 1'b0);
    endtask
    // mid-run reset must clear every register that was written before
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        gp = 8'h00;
        br = 8'h00;
        kp = 8'h00;
        repeat (4) @(negedge clock);
        chk(ctrl, ex());
        chk(20'({busy, gain, sda_oe}), 20'h0);
        wreg(8'ha0, 8'h5a);
    endtask
    initial begin
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        t_regs();
        t_levels();
        t_refuse();
        t_restart();
        t_gain();
        t_reset();
        end_sim();
    end
    // about six and a half times the expected run
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        end_sim();
    end
endmodule // ldc_top_tb_top
`default_nettype wire
